/* flash_status_id_lockout_ctl.sv */
// host controller that drives the flash pins for program, id and lockout sequences
// Functional notes
// [R1] every byte load of a protected program carries the same sector address bits
// [R2] unloaded bytes of a programmed sector become undefined in the device
// [R3] device toggle status flips on each read strobe while programming
// [R4] host compares successive toggle reads, assumes no fixed polarity
// [R5] host polls at one fixed address throughout toggle polling
// [R6] id mode returns maker byte at address 0, part byte at address 1
// [R7] id mode is lost on power loss; device reads normally afterwards
// [R8] id exit sequence returns device to normal read and program
// [R9] command writes use byte data and 15-bit hex addresses
// [R10] one lockout variant permanently locks the low boot block
// [R11] other lockout variant permanently locks the high boot block
// [R12] protection state takes effect when the accompanying program cycle ends
// [R13] host issues each byte load within the maximum byte-load interval; code waits on wr_data_valid with no load-interval timer
// [R14] protected program loads all bytes of the sector in one cycle
// [R15] while programming, the poll pin returns the complement of the last bit
`include "flash_host_defs.svh"
module flash_status_id_lockout_ctl
  import flash_host_pkg::*;
#(
  parameter int unsigned SECTOR_BYTES = `SECTOR_BYTES,
  parameter int unsigned POLL_LIMIT   = 4000000,
  parameter int unsigned LOAD_GAP_CYC = `T_BLC_CYC
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        req_valid,
  input  flash_host_pkg::host_op_t req_op,
  input  wire logic [16:0] req_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_data_valid,
  output logic             wr_data_ready,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [7:0]       resp_data,
  output logic             resp_timeout,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [16:0]      flash_addr,
  output logic [7:0]       flash_data_out,
  output logic             flash_data_oe,
  input  wire logic [7:0]  flash_data_in
);
  import flash_host_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b00000001,
    ST_CMD   = 8'b00000010,
    ST_LOAD  = 8'b00000100,
    ST_POLL1 = 8'b00001000,
    ST_POLL2 = 8'b00010000,
    ST_READ  = 8'b00100000,
    ST_RESP  = 8'b01000000,
    ST_GAP   = 8'b10000000
  } state_t;

  // ==========================================================
  // pin input synchroniser
  logic [7:0] din_meta_reg;
  logic [7:0] din_sync_reg;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end else begin
      din_meta_reg <= flash_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ==========================================================
  // command sequence table
  state_t     state_reg;
  host_op_t   op_reg;
  logic [16:0] addr_reg;
  logic [2:0] step_reg;
  logic [2:0] nsteps;
  logic [7:0] cnt_bytes_reg;
  logic [7:0] prev_reg;
  logic [31:0] poll_cnt_reg;
  logic [31:0] gap_cnt_reg;
  logic [14:0] seq_addr;
  logic [7:0] seq_data;

  always_comb begin
    nsteps = 3'd3;
    if (op_reg == OP_LOCK_LO || op_reg == OP_LOCK_HI) begin
      nsteps = 3'd6;
    end
  end

  // unlock pair, then operation byte; lockout adds a second unlock
  always_comb begin
    seq_addr = `CMD_ADDR_A; // R9
    seq_data = `CMD_DATA_UNLOCK1;
    unique case (step_reg)
      3'd0: begin seq_addr = `CMD_ADDR_A; seq_data = `CMD_DATA_UNLOCK1; end
      3'd1: begin seq_addr = `CMD_ADDR_B; seq_data = `CMD_DATA_UNLOCK2; end
      3'd2: begin
        seq_addr = `CMD_ADDR_A;
        unique case (op_reg)
          OP_PROGRAM: seq_data = `CMD_DATA_PROT;
          OP_ID_READ: seq_data = `CMD_DATA_ID_ENTRY;
          default:    seq_data = `CMD_DATA_LOCK_PRE;
        endcase
        if (id_exit_reg) begin
          seq_data = `CMD_DATA_ID_EXIT; // R8
        end
      end
      3'd3: begin seq_addr = `CMD_ADDR_A; seq_data = `CMD_DATA_UNLOCK1; end
      3'd4: begin seq_addr = `CMD_ADDR_B; seq_data = `CMD_DATA_UNLOCK2; end
      default: begin
        seq_addr = `CMD_ADDR_A;
        seq_data = (op_reg == OP_LOCK_LO) ? `CMD_DATA_LOCK_LO : `CMD_DATA_LOCK_HI; // R10 R11
      end
    endcase
  end

  // ==========================================================
  // bus cycle engine hookup
  logic        cyc_start;
  bus_kind_t   cyc_kind;
  logic [16:0] cyc_addr;
  logic [7:0]  cyc_wdata;
  logic        cyc_busy;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic        id_exit_reg;

  always_comb begin
    cyc_start = 1'b0;
    cyc_kind  = BUS_WRITE;
    cyc_addr  = {2'b00, seq_addr};
    cyc_wdata = seq_data;
    if (!cyc_busy && !cyc_done) begin
      unique case (state_reg)
        ST_CMD:  cyc_start = 1'b1;
        ST_LOAD: begin
          // sector bits held from the request; only the byte offset walks
          cyc_start = wr_data_valid;
          cyc_addr  = {addr_reg[16:`SECTOR_LSB], cnt_bytes_reg[6:0]}; // R1
          cyc_wdata = wr_data;
        end
        ST_POLL1, ST_POLL2, ST_READ: begin
          cyc_start = 1'b1;
          cyc_kind  = BUS_READ;
          cyc_addr  = addr_reg; // R5
        end
        default: cyc_start = 1'b0;
      endcase
    end
  end

  flash_bus_cycle u_cycle (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .start         (cyc_start),
    .kind          (cyc_kind),
    .addr          (cyc_addr),
    .wdata         (cyc_wdata),
    .pin_data_sync (din_sync_reg),
    .busy          (cyc_busy),
    .done          (cyc_done),
    .rdata         (cyc_rdata),
    .ce_n          (flash_ce_n),
    .oe_n          (flash_oe_n),
    .we_n          (flash_we_n),
    .addr_out      (flash_addr),
    .data_out      (flash_data_out),
    .data_oe       (flash_data_oe)
  );

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_data_ready <= 1'b0;
    end else begin
      wr_data_ready <= (state_reg == ST_LOAD) && !cyc_busy && !cyc_done && !wr_data_ready;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      op_reg        <= OP_READ;
      addr_reg      <= 17'h00000;
      step_reg      <= 3'd0;
      cnt_bytes_reg <= 8'h00;
      prev_reg      <= 8'h00;
      poll_cnt_reg  <= 32'h00000000;
      gap_cnt_reg   <= 32'h00000000;
      id_exit_reg   <= 1'b0;
      req_ready     <= 1'b0;
      resp_valid    <= 1'b0;
      resp_data     <= 8'h00;
      resp_timeout  <= 1'b0;
    end else begin
      // ready must not wait for valid to drop, or a waiting request deadlocks
      req_ready  <= (state_reg == ST_IDLE);
      resp_valid <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (req_valid && req_ready) begin
            op_reg        <= req_op;
            addr_reg      <= req_addr;
            step_reg      <= 3'd0;
            cnt_bytes_reg <= 8'h00;
            poll_cnt_reg  <= 32'h00000000;
            id_exit_reg   <= 1'b0;
            resp_timeout  <= 1'b0;
            req_ready     <= 1'b0;
            state_reg     <= (req_op == OP_READ) ? ST_READ : ST_CMD;
          end
        end
        ST_CMD: begin
          if (cyc_done) begin
            if (step_reg == nsteps - 3'd1) begin
              step_reg <= 3'd0;
              if (id_exit_reg) begin
                state_reg <= ST_RESP; // R8
              end else if (op_reg == OP_ID_READ) begin
                addr_reg  <= {16'h0000, addr_reg[0]}; // R6
                state_reg <= ST_READ;
              end else if (op_reg == OP_PROGRAM) begin
                state_reg <= ST_LOAD;
              end else begin
                state_reg <= ST_POLL1; // R12
              end
            end else begin
              step_reg <= step_reg + 3'd1;
            end
          end
        end
        ST_LOAD: begin
          // full sector before program starts; source stall risks the load interval
          if (cyc_done) begin
            if (cnt_bytes_reg == 8'(SECTOR_BYTES - 1)) begin // R14 R2 R13
              gap_cnt_reg <= 32'h00000000;
              state_reg   <= ST_GAP;
            end
            cnt_bytes_reg <= cnt_bytes_reg + 8'h01;
          end
        end
        ST_GAP: begin
          // polls inside the load window see stale data and would fake completion
          gap_cnt_reg <= gap_cnt_reg + 32'h00000001;
          if (gap_cnt_reg == 32'(LOAD_GAP_CYC)) begin // R13
            state_reg <= ST_POLL1;
          end
        end
        ST_POLL1: begin
          if (cyc_done) begin
            prev_reg  <= cyc_rdata;
            state_reg <= ST_POLL2;
          end
        end
        ST_POLL2: begin
          // done when two reads agree on the toggle bit; polarity is never assumed
          if (cyc_done) begin
            prev_reg     <= cyc_rdata;
            poll_cnt_reg <= poll_cnt_reg + 32'h00000001;
            if (cyc_rdata[6] == prev_reg[6]) begin // R3 R4 R15
              state_reg <= ST_READ;
            end else if (poll_cnt_reg == 32'(POLL_LIMIT)) begin
              resp_timeout <= 1'b1;
              state_reg    <= ST_RESP;
            end
          end
        end
        ST_READ: begin
          if (cyc_done) begin
            resp_data <= cyc_rdata;
            if (op_reg == OP_ID_READ) begin
              // leave id mode at once; power loss would also clear it
              id_exit_reg <= 1'b1; // R7
              op_reg      <= OP_READ;
              state_reg   <= ST_CMD;
            end else begin
              state_reg <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          resp_valid <= 1'b1;
          state_reg  <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

/* flash_host_defs.svh */
// constants for the flash host controller: command codes, pin timing and counts
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ==========================================================
// command sequence addresses and data (15-bit address, byte data)
`define CMD_ADDR_A        15'h5555
`define CMD_ADDR_B        15'h2aaa
`define CMD_DATA_UNLOCK1  8'haa
`define CMD_DATA_UNLOCK2  8'h55
`define CMD_DATA_PROT     8'ha0
`define CMD_DATA_ID_ENTRY 8'h90
`define CMD_DATA_ID_EXIT  8'hf0
`define CMD_DATA_LOCK_PRE 8'h80
`define CMD_DATA_LOCK_LO  8'h40
`define CMD_DATA_LOCK_HI  8'h60

// ==========================================================
// sector geometry
`define SECTOR_BYTES      128
`define SECTOR_LSB        7

// ==========================================================
// timing in ns, cycles derived at 5 ns clock
`define CLK_PERIOD_NS     5
`define T_WP_NS           90
`define T_WPH_NS          100
`define T_ACC_NS          150
`define T_OEHP_NS         150
`define T_WP_CYC          ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WPH_CYC         ((`T_WPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_ACC_CYC         ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_OEHP_CYC        ((`T_OEHP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// longest quiet span between byte loads before the device starts programming
`define T_BLC_NS          150000
`define T_BLC_CYC         ((`T_BLC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* flash_host_pkg.sv */
// types for the flash host controller
package flash_host_pkg;
  typedef enum logic [3:0] {
    OP_READ     = 4'h0,
    OP_PROGRAM  = 4'h1,
    OP_ID_READ  = 4'h2,
    OP_LOCK_LO  = 4'h3,
    OP_LOCK_HI  = 4'h4
  } host_op_t;

  typedef enum logic [1:0] {
    BUS_WRITE = 2'h0,
    BUS_READ  = 2'h1
  } bus_kind_t;
endpackage

/* flash_bus_cycle.sv */
// single strobe cycle engine: one write or one read on the flash pins
`include "flash_host_defs.svh"
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reset,
  input  wire logic      start,
  input  flash_host_pkg::bus_kind_t kind,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  pin_data_sync,
  output logic           busy,
  output logic           done,
  output logic [7:0]     rdata,
  output logic           ce_n,
  output logic           oe_n,
  output logic           we_n,
  output logic [16:0]    addr_out,
  output logic [7:0]     data_out,
  output logic           data_oe
);
  // ==========================================================
  // strobe phase then recovery phase; read waits access time plus sync delay
  localparam int unsigned SYNC_CYC = 2;
  logic [7:0] cnt_reg;
  logic       phase_reg;
  logic       is_read_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy        <= 1'b0;
      done        <= 1'b0;
      phase_reg   <= 1'b0;
      is_read_reg <= 1'b0;
      cnt_reg     <= 8'h00;
      ce_n        <= 1'b1;
      oe_n        <= 1'b1;
      we_n        <= 1'b1;
      addr_out    <= 17'h00000;
      data_out    <= 8'h00;
      data_oe     <= 1'b0;
      rdata       <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy        <= 1'b1;
        phase_reg   <= 1'b0;
        is_read_reg <= (kind == BUS_READ);
        addr_out    <= addr;
        ce_n        <= 1'b0;
        if (kind == BUS_READ) begin
          oe_n    <= 1'b0;
          data_oe <= 1'b0;
          cnt_reg <= 8'(`T_ACC_CYC + SYNC_CYC);
        end else begin
          // output enable stays high while both write strobes are low
          we_n     <= 1'b0;
          data_out <= wdata;
          data_oe  <= 1'b1;
          cnt_reg  <= 8'(`T_WP_CYC);
        end
      end else if (busy) begin
        if (cnt_reg != 8'h00) begin
          cnt_reg <= cnt_reg - 8'h01;
        end else if (!phase_reg) begin
          phase_reg <= 1'b1;
          ce_n      <= 1'b1;
          oe_n      <= 1'b1;
          we_n      <= 1'b1;
          if (is_read_reg) begin
            rdata <= pin_data_sync;
          end
          // high time also gives the toggle status its oe high pulse
          cnt_reg <= 8'(is_read_reg ? `T_OEHP_CYC : `T_WPH_CYC);
        end else begin
          busy    <= 1'b0;
          done    <= 1'b1;
          data_oe <= 1'b0;
        end
      end
    end
  end
endmodule

/* flash_ctl_props.sv */
// checker: pin timing and handshake of the flash host controller
`include "flash_host_defs.svh"
module flash_ctl_checker #(
  parameter int unsigned SECTOR_BYTES = 128,
  parameter int unsigned POLL_LIMIT = 50
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [16:0] flash_addr,
  input wire logic [7:0] flash_data_out,
  input wire logic flash_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  // ==========
  // write strobe low and high time, saturating so idle spans stay legal
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) lo_cnt <= 8'h00;
    else if (flash_we_n) lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) hi_cnt <= 8'hff;
    else if (!flash_we_n) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
  end
  sequence s_wr_start;
    $fell(flash_we_n);
  endsequence
  sequence s_wr_end;
    $rose(flash_we_n);
  endsequence
  property p_wp_width;
    s_wr_end |-> lo_cnt >= `T_WP_CYC;
  endproperty
  a_wp_width: assert property (p_wp_width) else $error("write pulse too short");
  property p_wph_width;
    s_wr_start |-> hi_cnt >= `T_WPH_CYC;
  endproperty
  a_wph_width: assert property (p_wph_width) else $error("write high too short");
  property p_ce_with_we;
    s_wr_start |-> !flash_ce_n;
  endproperty
  a_ce_with_we: assert property (p_ce_with_we) else $error("write without select");
  property p_oe_off;
    !flash_we_n |-> flash_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe low during write");
  property p_drive_wr;
    !flash_we_n |-> flash_data_oe;
  endproperty
  a_drive_wr: assert property (p_drive_wr) else $error("data not driven in write");
  property p_float_rd;
    !flash_oe_n |-> !flash_data_oe;
  endproperty
  a_float_rd: assert property (p_float_rd) else $error("bus driven during read");
  property p_wr_stable;
    !flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_data_out);
  endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("address moved in write");
  property p_resp_pulse;
    resp_valid |=> !resp_valid;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("response longer than one cycle");
  property p_take_drop;
    req_valid && req_ready |=> !req_ready;
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("ready stayed after take");
endmodule
bind flash_status_id_lockout_ctl flash_ctl_checker #(
  .SECTOR_BYTES(SECTOR_BYTES), .POLL_LIMIT(POLL_LIMIT)) u_chk (
  .sys_clk, .reset, .req_valid, .req_ready, .resp_valid, .flash_ce_n, .flash_oe_n,
  .flash_we_n, .flash_addr, .flash_data_out, .flash_data_oe);

/* flash_dev_model.sv */
// behavioural flash device seen from its pins, with a program timer
`include "flash_host_defs.svh"
module flash_dev_model #(
  parameter int BLC_NS = 2000,
  parameter int PROG_NS = 10000,
  parameter int BOOT_BYTES = 8192,
  parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h7a   // arbitrary value
) (
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [16:0] flash_addr,
  input wire logic [7:0] flash_data_out,
  input wire logic stuck,
  output logic [7:0] flash_data_in,
  output int bad_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [int];
  logic [7:0] pbuf [128];
  bit pvld [128];
  logic [16:0] wa, sec_a, poll_a;
  logic [7:0] wd, lastb, rv;
  int step, nld;
  bit loading, busy, idm, pre, lk_lo, lk_hi, prot_on, tog, pset;
  time last_t;
  wire wr = !flash_ce_n && !flash_we_n;
  wire rd = !flash_ce_n && !flash_oe_n;
  initial begin
    bad_cnt = 0;
    flash_data_in = 8'h00;
    idm = 0;
  end
  // sample mid pulse: strobes and bus move on the same clock edge
  always @(posedge wr) begin
    #45;
    wa = flash_addr;
    wd = flash_data_out;
    if (loading && nld > 0 && wa[16:7] != sec_a[16:7]) bad_cnt++;
  end
  always @(negedge wr) begin
    if (busy) step = 0;
    else if (loading) begin
      if (nld == 0) sec_a = wa;
      pbuf[wa[6:0]] = wd;
      pvld[wa[6:0]] = 1;
      lastb = wd;
      last_t = $time;
      nld++;
    end else if (step == 0) step = (wa[14:0] == `CMD_ADDR_A && wd == `CMD_DATA_UNLOCK1) ? 1 : 0;
    else if (step == 1) step = (wa[14:0] == `CMD_ADDR_B && wd == `CMD_DATA_UNLOCK2) ? 2 : 0;
    else begin
      step = 0;
      if (wa[14:0] == `CMD_ADDR_A) begin
        case (wd)
          `CMD_DATA_PROT: loading = 1;
          `CMD_DATA_ID_ENTRY: idm = 1;
          `CMD_DATA_ID_EXIT: idm = 0;
          `CMD_DATA_LOCK_LO: lk_lo |= pre;
          `CMD_DATA_LOCK_HI: lk_hi |= pre;
          default: ;
        endcase
        pre = (wd == `CMD_DATA_LOCK_PRE);
      end
    end
  end
  initial forever begin
    #100;
    if (loading && nld > 0 && $time - last_t > BLC_NS) begin
      loading = 0;
      if (nld != `SECTOR_BYTES) bad_cnt++;
      for (int i = 0; i < 128; i++) begin
        if (!((lk_lo && sec_a < BOOT_BYTES) || (lk_hi && int'(sec_a) >= 32'h20000 - BOOT_BYTES)))
          mem[{sec_a[16:7], i[6:0]}] = pvld[i] ? pbuf[i] : 8'hxx;
        pvld[i] = 0;
      end
      nld = 0;
      pset = 0;
      busy = 1;
    end
  end
  always @(posedge busy) begin
    #PROG_NS;
    wait (!stuck);
    busy = 0;
    prot_on = 1;
  end
  always @(posedge rd) begin
    #10;
    if (busy) begin
      tog = ~tog;
      if (pset && flash_addr != poll_a) bad_cnt++;
      poll_a = flash_addr;
      pset = 1;
      rv = {~lastb[7], tog, 6'h00};
    end else if (idm && flash_addr[15:1] == 15'h0000) rv = flash_addr[0] ? PART_ID : MAKER_ID;
    else rv = mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 8'hff;
    flash_data_in = rv;
  end
  // a released bus must not keep the last value
  always @(negedge rd) flash_data_in = ~rv;
endmodule

/* tb_top.sv */
// self-checking bench for the flash host controller with a device model
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_host_pkg::*;
  logic sys_clk, reset, req_valid, wr_data_valid, stuck;
  host_op_t req_op;
  logic [16:0] req_addr, flash_addr;
  logic [7:0] pat_base, resp_data, flash_data_out, flash_data_in;
  logic wr_data_ready, req_ready, resp_valid, resp_timeout;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_data_oe;
  int error_cnt, num_checks, bad_cnt, load_idx;
  wire logic [7:0] wr_data = 8'(load_idx) ^ pat_base;
  flash_status_id_lockout_ctl #(.POLL_LIMIT(50), .LOAD_GAP_CYC(440)) dut (
    .sys_clk, .reset, .req_valid, .req_op, .req_addr, .wr_data, .wr_data_valid,
    .wr_data_ready, .req_ready, .resp_valid, .resp_data, .resp_timeout, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .flash_addr, .flash_data_out, .flash_data_oe, .flash_data_in);
  flash_dev_model dev (
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_data_out, .stuck,
    .flash_data_in, .bad_cnt);
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (wr_data_valid && wr_data_ready) load_idx <= load_idx + 1;
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input host_op_t op, input logic [16:0] a, input int lim);
    int i;
    @(posedge sys_clk);
    #1;
    req_valid = 1;
    req_op = op;
    req_addr = a;
    for (i = 0; i < 300 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (i >= 300) begin
      error_cnt++;
      $display("BAD %0t request not taken", $time);
      report_and_stop;
    end
    @(posedge sys_clk);
    #1;
    req_valid = 0;
    for (i = 0; i < lim && resp_valid !== 1'b1; i++) @(negedge sys_clk);
    if (i >= lim) begin
      error_cnt++;
      $display("BAD %0t no response", $time);
      report_and_stop;
    end
  endtask
  task automatic t_read(input host_op_t op, input logic [16:0] a, input logic [7:0] exp);
    issue(op, a, 3000);
    chk(resp_data, exp);
  endtask
  task automatic t_prog(input logic [16:0] a, input logic [7:0] s, input logic to);
    pat_base = s;
    load_idx = 0;
    issue(OP_PROGRAM, a, 30000);
    chk({7'h00, resp_timeout}, {7'h00, to});
  endtask
  task t_idle;
    chk({flash_ce_n, flash_oe_n, flash_we_n, flash_data_oe, resp_valid, 3'h0}, 8'he0);
  endtask
  task t_sector;
    t_prog(17'h08080, 8'h5a, 1'b0);
    t_read(OP_READ, 17'h08080, 8'h5a);
    t_read(OP_READ, 17'h080ff, 8'h25);
    t_read(OP_READ, 17'h00000, 8'hff);
  endtask
  task t_ident;
    t_read(OP_ID_READ, 17'h00000, 8'h3c);
    t_read(OP_ID_READ, 17'h00001, 8'h7a);
    t_read(OP_READ, 17'h08081, 8'h5b);
  endtask
  task automatic t_lock(input host_op_t op, input logic [16:0] a, input logic [7:0] exp);
    t_prog(a, 8'h11, 1'b0);
    issue(op, a, 3000);
    t_prog(a, 8'h22, 1'b0);
    t_read(OP_READ, a + 17'h00005, exp);
  endtask
  task t_stuck;
    stuck = 1;
    t_prog(17'h04000, 8'h66, 1'b1);
    stuck = 0;
  endtask
  initial begin
    reset = 1;
    req_valid = 0;
    req_op = OP_READ;
    req_addr = 17'h00000;
    wr_data_valid = 0;
    stuck = 0;
    pat_base = 8'h00;
    load_idx = 0;
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    reset = 0;
    wr_data_valid = 1;
    t_idle;
    t_sector;
    t_ident;
    t_lock(OP_LOCK_LO, 17'h00100, 8'h14);
    t_lock(OP_LOCK_HI, 17'h1ff00, 8'h14);
    t_stuck;
    chk(bad_cnt[7:0], 8'h00);
    report_and_stop;
  end
endmodule
